// *** design/pdhs_defs.svh ***
// timing counts and constants for the powered-device hotswap sequencer
`ifndef PDHS_DEFS_SVH
`define PDHS_DEFS_SVH

`define PDHS_CLK_MHZ          200
`define PDHS_DWELL_MS         80
`define PDHS_OVL_US           140
// least times round up; both are exact at 200 MHz
`define PDHS_DWELL_CYC        (`PDHS_DWELL_MS * 1000 * `PDHS_CLK_MHZ)
`define PDHS_OVL_CYC          (`PDHS_OVL_US * `PDHS_CLK_MHZ)
`define PDHS_CNT_W            25
`define PDHS_SOFT_BASE_CYC    25'h0000400
`define PDHS_SOFT_LOAD_SHIFT  4

`endif

// *** design/pdhs_pkg.sv ***
// types for the powered-device hotswap sequencer
package pdhs_pkg;

	typedef enum logic [1:0] {
		PDHS_SW_OFF,
		PDHS_SW_CHARGE,
		PDHS_SW_ON,
		PDHS_SW_FAULT
	} pdhs_sw_state_type;

	typedef enum logic [2:0] {
		PDHS_CL_IDLE,
		PDHS_CL_DETECT,
		PDHS_CL_CLASS1,
		PDHS_CL_MARK1,
		PDHS_CL_CLASS2,
		PDHS_CL_SECOND_MARK_STEP,
		PDHS_CL_DONE
	} pdhs_class_state_type;

	// line-side comparator levels
	typedef struct packed {
		logic detect_range;    // line within detection window
		logic class_level;     // line above classification threshold
		logic below_mark;      // line below mark threshold
		logic above_undervoltage_lockout;      // line above rising lockout threshold
	} pdhs_line_type;

	// switch comparator levels
	typedef struct packed {
		logic below_on;        // switch voltage below turn-on threshold
		logic above_ovl;       // switch voltage above overload threshold
		logic above_off;       // switch voltage above switch-off threshold
		logic low_current;     // current below keep-alive threshold
		logic above_surge;     // rail difference above surge trip level
	} pdhs_sense_type;

endpackage : pdhs_pkg

// *** design/pdhs_sequencer.sv ***
// powered-device line sequencing and hotswap switch machine
//
// Operation
// - lockout forces switch off and disconnected
// - full detection and classification before enabling switch
// - switch enabled above rising lockout threshold
// - enabling enters charge-limit current regulation state
// - charge to on below 380 mV; 80 ms two-event
// - on to fault after 3.5 V held 140 us
// - fault to on below 380 mV after 80 ms
// - overload limits current, resumes after wait and threshold
// - on to fault current limit above switch-off threshold
// - keep-alive pulses when on, low current, autosleep
// - invalid detection signature during first mark
// - two-event sequence drives high-power grant low
// - surge clamp only above trip with switch off
// - sense external gate tie at startup
// - external switch keeps inrush limit and keep-alive
// - internal soft start scaled by connected load
`timescale 1ns/1ps
`include "pdhs_defs.svh"

module pdhs_sequencer (
	input  wire logic                    core_clk,            // oscillator clock
	input  wire logic                    rst,                 // lockout reset, active high
	input  wire pdhs_pkg::pdhs_line_type  line_in,             // line comparators
	input  wire pdhs_pkg::pdhs_sense_type sense_in,            // switch comparators
	input  wire logic                    undervoltage_lockout, // lockout engaged
	input  wire logic                    autosleep_en,        // automatic sleep enabled
	input  wire logic                    ext_switch_gate,     // gate pin sensed high
	input  wire logic                    soft_load_hi,        // heavy load seen at start
	output logic                         switch_output,       // switch output connected
	output logic                         negative_rail,       // negative rail connected
	output logic                         current_limit,       // closed-loop limit active
	output logic                         ext_gate_drive,      // external transistor gate on
	output logic                         detect_sig_en,       // detection signature valid
	output logic                         keepalive_req,       // keep-alive pulse request
	output logic                         high_power_grant_n,  // high power, active low
	output logic                         surge_clamp,         // surge clamp engaged
	output logic                         converter_run,       // converter enabled
	output logic                         soft_start_done,     // soft start finished
	output pdhs_pkg::pdhs_sw_state_type   sw_state             // switch machine state
);
	import pdhs_pkg::*;

	localparam logic [`PDHS_CNT_W-1:0] DWELL_CYC = `PDHS_CNT_W'(`PDHS_DWELL_CYC);
	localparam logic [`PDHS_CNT_W-1:0] OVL_CYC   = `PDHS_CNT_W'(`PDHS_OVL_CYC);

	pdhs_sw_state_type    sw_state_reg;
	pdhs_sw_state_type    sw_state_next;
	pdhs_class_state_type cl_state_reg;
	logic                 two_event_reg;
	logic                 class_done_reg;
	logic                 ext_sel_reg;
	logic                 strap_taken_reg;
	logic [`PDHS_CNT_W-1:0] dwell_cnt_reg;
	logic [`PDHS_CNT_W-1:0] ovl_cnt_reg;
	logic [`PDHS_CNT_W-1:0] soft_cnt_reg;
	logic [`PDHS_CNT_W-1:0] soft_len_reg;
	logic                 dwell_ok;
	logic                 ovl_ok;

	assign dwell_ok = (dwell_cnt_reg >= DWELL_CYC - `PDHS_CNT_W'(1));
	assign ovl_ok   = (ovl_cnt_reg >= OVL_CYC - `PDHS_CNT_W'(1));

	// classification tracker; a second class event marks two-event mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cl_state_reg   <= PDHS_CL_IDLE;
			two_event_reg  <= 1'b0;
			class_done_reg <= 1'b0;
		end else if (sw_state_reg != PDHS_SW_OFF) begin
			cl_state_reg <= cl_state_reg; // sequence frozen once powered
		end else begin
			unique case (cl_state_reg)
				PDHS_CL_IDLE: begin
					if (line_in.detect_range) begin
						cl_state_reg <= PDHS_CL_DETECT;
					end
				end
				PDHS_CL_DETECT: begin
					if (line_in.class_level) begin
						cl_state_reg <= PDHS_CL_CLASS1;
					end
				end
				PDHS_CL_CLASS1: begin
					if (line_in.below_mark) begin
						cl_state_reg <= PDHS_CL_MARK1;
					end else if (line_in.above_undervoltage_lockout) begin
						cl_state_reg   <= PDHS_CL_DONE;
						class_done_reg <= 1'b1; // single event complete
					end
				end
				PDHS_CL_MARK1: begin
					if (line_in.class_level) begin
						cl_state_reg <= PDHS_CL_CLASS2;
					end
				end
				PDHS_CL_CLASS2: begin
					if (line_in.below_mark) begin
						cl_state_reg <= PDHS_CL_SECOND_MARK_STEP;
					end
				end
				PDHS_CL_SECOND_MARK_STEP: begin
					if (line_in.above_undervoltage_lockout) begin
						cl_state_reg   <= PDHS_CL_DONE;
						two_event_reg  <= 1'b1;
						class_done_reg <= 1'b1;
					end
				end
				PDHS_CL_DONE: begin
					cl_state_reg <= PDHS_CL_DONE;
				end
			endcase
		end
	end

	// switch machine next state; lockout overrides all else, switch-off overrides only in the on state
	always_comb begin
		sw_state_next = sw_state_reg;
		if (undervoltage_lockout) begin
			sw_state_next = PDHS_SW_OFF;
		end else if (sense_in.above_off && sw_state_reg == PDHS_SW_ON) begin
			sw_state_next = PDHS_SW_FAULT;
		end else begin
			unique case (sw_state_reg)
				PDHS_SW_OFF: begin
					if (class_done_reg && line_in.above_undervoltage_lockout) begin
						sw_state_next = PDHS_SW_CHARGE;
					end
				end
				PDHS_SW_CHARGE: begin
					if (sense_in.below_on && (!two_event_reg || dwell_ok)) begin
						sw_state_next = PDHS_SW_ON;
					end
				end
				PDHS_SW_ON: begin
					if (ovl_ok) begin
						sw_state_next = PDHS_SW_FAULT;
					end
				end
				PDHS_SW_FAULT: begin
					if (sense_in.below_on && dwell_ok) begin
						sw_state_next = PDHS_SW_ON;
					end
				end
			endcase
		end
	end

	// switch state register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sw_state_reg <= PDHS_SW_OFF;
		end else begin
			sw_state_reg <= sw_state_next;
		end
	end

	// dwell timer restarts on every state change so it measures time in state
	always_ff @(posedge core_clk) begin
		if (rst || sw_state_next != sw_state_reg) begin
			dwell_cnt_reg <= '0;
		end else if (!dwell_ok) begin
			dwell_cnt_reg <= dwell_cnt_reg + `PDHS_CNT_W'(1);
		end
	end

	// overload filter: voltage must stay high without a break
	always_ff @(posedge core_clk) begin
		if (rst || sw_state_reg != PDHS_SW_ON || !sense_in.above_ovl) begin
			ovl_cnt_reg <= '0;
		end else if (!ovl_ok) begin
			ovl_cnt_reg <= ovl_cnt_reg + `PDHS_CNT_W'(1);
		end
	end

	// gate pin strap caught once after release, never under reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ext_sel_reg     <= 1'b0;
			strap_taken_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			ext_sel_reg     <= ext_switch_gate;
			strap_taken_reg <= 1'b1;
		end
	end

	// soft start length scales with load; the converter runs as soon as the switch is on, not after soft start
	always_ff @(posedge core_clk) begin
		if (rst || sw_state_reg != PDHS_SW_ON) begin
			soft_cnt_reg <= '0;
			soft_len_reg <= `PDHS_SOFT_BASE_CYC;
		end else begin
			if (soft_cnt_reg == '0) begin
				soft_len_reg <= soft_load_hi ?
					(`PDHS_SOFT_BASE_CYC << `PDHS_SOFT_LOAD_SHIFT) :
					`PDHS_SOFT_BASE_CYC;
			end
			if (soft_cnt_reg != soft_len_reg) begin
				soft_cnt_reg <= soft_cnt_reg + `PDHS_CNT_W'(1);
			end
		end
	end

	// registered outputs; data outputs come from flip-flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			switch_output      <= 1'b0;
			negative_rail      <= 1'b0;
			current_limit      <= 1'b0;
			ext_gate_drive     <= 1'b0;
			detect_sig_en      <= 1'b1;
			keepalive_req      <= 1'b0;
			high_power_grant_n <= 1'b1;
			surge_clamp        <= 1'b0;
			converter_run      <= 1'b0;
			soft_start_done    <= 1'b0;
		end else begin
			switch_output  <= (sw_state_reg != PDHS_SW_OFF);
			negative_rail  <= (sw_state_reg != PDHS_SW_OFF);
			current_limit  <= (sw_state_reg == PDHS_SW_CHARGE) ||
				(sw_state_reg == PDHS_SW_FAULT);
			// external transistor only fully on with the internal path; limit kept inside
			ext_gate_drive <= ext_sel_reg && (sw_state_reg == PDHS_SW_ON) &&
				!sense_in.low_current;
			detect_sig_en  <= (cl_state_reg != PDHS_CL_MARK1);
			keepalive_req  <= (sw_state_reg == PDHS_SW_ON) && sense_in.low_current &&
				autosleep_en;
			high_power_grant_n <= !(two_event_reg && sw_state_reg != PDHS_SW_OFF);
			surge_clamp    <= sense_in.above_surge && (sw_state_reg == PDHS_SW_OFF);
			converter_run  <= (sw_state_reg == PDHS_SW_ON);
			soft_start_done <= (sw_state_reg == PDHS_SW_ON) &&
				(soft_cnt_reg == soft_len_reg) && (soft_cnt_reg != '0);
		end
	end

	assign sw_state = sw_state_reg;

endmodule : pdhs_sequencer

// *** verification/pdhs_pse_model.sv ***
// line-side model of the power sourcing equipment
`timescale 1ns/1ps
module pdhs_pse_model (
	input  wire logic        core_clk, // paces the steps
	input  wire logic        rst,      // cable pulled
	input  wire logic        go,       // start a power-up
	input  wire logic        two_ev,   // two-event class
	input  wire logic [7:0]  step,     // cycles per step
	output pdhs_pkg::pdhs_line_type line_out // line levels
);
	import pdhs_pkg::*;
	// one level per step, changed on falling edges like the bench
	task automatic put(input logic [3:0] v);
		line_out = v;
		repeat (step) @(negedge core_clk);
	endtask : put
	initial line_out = '0;
	always @(posedge rst) line_out = '0;
	// detection, class, marks only for two-event, then full voltage
	always @(posedge go) begin
		put(4'h8);
		put(4'h4);
		if (two_ev) begin
			put(4'h2);
			put(4'h4);
			put(4'h2);
		end
		line_out = 4'h1;
	end
endmodule : pdhs_pse_model

// *** verification/pdhs_seq_sva.sv ***
// port assertions for the hotswap sequencer
`timescale 1ns/1ps
module pdhs_seq_sva (
	input wire logic                     core_clk,             // clock
	input wire logic                     rst,                  // reset
	input wire pdhs_pkg::pdhs_line_type  line_in,              // line levels
	input wire pdhs_pkg::pdhs_sense_type sense_in,             // switch levels
	input wire logic                     undervoltage_lockout, // lockout
	input wire logic                     autosleep_en,         // auto sleep
	input wire logic                     switch_output,        // switch on
	input wire logic                     current_limit,        // limit mode
	input wire logic                     keepalive_req,        // keep-alive
	input wire logic                     high_power_grant_n,   // grant, low
	input wire logic                     surge_clamp,          // clamp
	input wire pdhs_pkg::pdhs_sw_state_type sw_state           // machine state
);
	import pdhs_pkg::*;
	// outputs lag the state by one edge, so most checks look one edge back
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_lock_off: assert property (undervoltage_lockout |=> sw_state == PDHS_SW_OFF)
		else $error("lockout left switch on");
	a_enter_charge: assert property ($past(sw_state) == PDHS_SW_OFF && sw_state != PDHS_SW_OFF
		|-> sw_state == PDHS_SW_CHARGE && $past(line_in.above_undervoltage_lockout)) else $error("bad turn-on");
	a_limit_mode: assert property (current_limit ==
		($past(sw_state) inside {PDHS_SW_CHARGE, PDHS_SW_FAULT})) else $error("limit mode wrong");
	a_fault_cause: assert property ($past(sw_state) == PDHS_SW_ON && sw_state == PDHS_SW_FAULT
		|-> $past(sense_in.above_ovl || sense_in.above_off)) else $error("fault without cause");
	a_trip_fault: assert property (sw_state == PDHS_SW_ON && sense_in.above_off
		&& !undervoltage_lockout |=> sw_state == PDHS_SW_FAULT) else $error("trip ignored");
	a_keepalive_gate: assert property (keepalive_req
		|-> $past(autosleep_en && sense_in.low_current)) else $error("keep-alive unasked");
	a_clamp_off: assert property (surge_clamp
		|-> $past(sense_in.above_surge) && !switch_output) else $error("clamp while on");
	a_grant_off: assert property (sw_state == PDHS_SW_OFF |=> high_power_grant_n)
		else $error("grant while off");
	c_on: cover property (sw_state == PDHS_SW_ON);
	c_fault: cover property (sw_state == PDHS_SW_FAULT);
	c_grant: cover property (!high_power_grant_n);
endmodule : pdhs_seq_sva
bind pdhs_sequencer pdhs_seq_sva sva_i (.core_clk, .rst, .line_in, .sense_in,
	.undervoltage_lockout, .autosleep_en, .switch_output, .current_limit, .keepalive_req,
	.high_power_grant_n, .surge_clamp, .sw_state);

// *** verification/tb_top.sv ***
// self-checking bench for the hotswap sequencer
`timescale 1ns/1ps
module tb_top;
	import pdhs_pkg::*;
	logic core_clk, rst, undervoltage_lockout, autosleep_en, ext_switch_gate, go, two_ev;
	logic switch_output, negative_rail, current_limit, ext_gate_drive, detect_sig_en;
	logic keepalive_req, high_power_grant_n, surge_clamp, converter_run, soft_start_done;
	logic [7:0] step;
	logic soft_load_hi;
	pdhs_line_type line_in;
	pdhs_sense_type sense_in;
	pdhs_sw_state_type sw_state;
	int fails, comparisons;
	pdhs_sequencer dut (.core_clk, .rst, .line_in, .sense_in, .undervoltage_lockout,
		.autosleep_en, .ext_switch_gate, .soft_load_hi, .switch_output, .negative_rail,
		.current_limit, .ext_gate_drive, .detect_sig_en, .keepalive_req, .high_power_grant_n,
		.surge_clamp, .converter_run, .soft_start_done, .sw_state);
	pdhs_pse_model pse (.core_clk, .rst, .go, .two_ev, .step, .line_out(line_in));
	// 200 MHz
	initial begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	// bounded wait; a hang shows up as a state mismatch
	task automatic wait_st(input pdhs_sw_state_type s);
		for (int i = 0; i < 300 && sw_state !== s; i++) cyc(1);
		chk(sw_state, s);
	endtask : wait_st
	// reset held 8 cycles, then the equipment runs its sequence
	task automatic power_up(input logic t, input logic [7:0] s);
		rst = 1;
		go = 0;
		sense_in = '0;
		undervoltage_lockout = 0;
		two_ev = t;
		step = s;
		cyc(8);
		rst = 0;
		cyc(1);
		chk({sw_state, switch_output, detect_sig_en, high_power_grant_n}, 5'h03);
		go = 1;
		wait_st(PDHS_SW_CHARGE);
	endtask : power_up
	task automatic t_single;
		ext_switch_gate = 1;
		power_up(0, 8'h03);
		cyc(2);
		chk({switch_output, negative_rail, current_limit, high_power_grant_n}, 4'hF);
		sense_in.below_on = 1;
		cyc(1);
		chk(sw_state, PDHS_SW_ON);
		cyc(1);
		chk({current_limit, ext_gate_drive, converter_run, soft_start_done}, 4'h6);
		sense_in.low_current = 1;
		cyc(2);
		chk({keepalive_req, ext_gate_drive}, 2'h2);
		autosleep_en = 0;
		cyc(2);
		chk(keepalive_req, 1'b0);
		sense_in.above_ovl = 1;
		sense_in.above_surge = 1;
		cyc(27990);
		chk({sw_state, surge_clamp, soft_start_done}, {PDHS_SW_ON, 2'b01});
		cyc(20);
		chk(sw_state, PDHS_SW_FAULT);
		sense_in.above_ovl = 0;
		cyc(100);
		chk({sw_state, current_limit}, {PDHS_SW_FAULT, 1'b1});
		undervoltage_lockout = 1;
		cyc(1);
		chk(sw_state, PDHS_SW_OFF);
		cyc(2);
		chk({switch_output, negative_rail, surge_clamp}, 3'h1);
		$display("test single done");
	endtask : t_single
	// mark check runs beside the power-up
	task automatic t_two;
		fork
			power_up(1, 8'h14);
			begin
				cyc(12);
				wait (line_in.below_mark);
				cyc(3);
				chk(detect_sig_en, 1'b0);
			end
		join
		cyc(2);
		chk(high_power_grant_n, 1'b0);
		sense_in.below_on = 1;
		cyc(50);
		chk(sw_state, PDHS_SW_CHARGE);
		$display("test two done");
	endtask : t_two
	task automatic t_trip;
		soft_load_hi = 1;
		power_up(0, 8'h01);
		sense_in.below_on = 1;
		cyc(2);
		chk(sw_state, PDHS_SW_ON);
		// heavy load stretches soft start well past the light-load length
		cyc(1100);
		chk(soft_start_done, 1'b0);
		sense_in.above_off = 1;
		cyc(1);
		chk(sw_state, PDHS_SW_FAULT);
		$display("test trip done");
	endtask : t_trip
	task automatic close_out;
		$display("counts: %0d comparisons, %0d fails", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	initial begin
		{rst, go, two_ev, undervoltage_lockout, ext_switch_gate, autosleep_en} = 6'h21;
		step = 8'h01;
		soft_load_hi = 0;
		sense_in = '0;
		t_single;
		t_two;
		t_trip;
		close_out;
	end
	// tests need about 30,000 cycles
	initial begin
		#400000;
		fails++;
		close_out;
	end
endmodule : tb_top
